// ### logic/ssat_pkg.sv
// Package with constants and types for the single-slope converter timing and capture block.
// ****************************************
// How it works
// ****************************************
package ssat_pkg;

  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_WIDTH = 4'h1;
  localparam logic [3:0] ADDR_TRIM = 4'h2;
  localparam logic [3:0] ADDR_RES1 = 4'h3;
  localparam logic [3:0] ADDR_RES2 = 4'h4;
  localparam logic [3:0] ADDR_RES3 = 4'h5;
  localparam logic [3:0] ADDR_RESAUX = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;

  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_RATE_BIT = 7;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [2:0] TRIM_RESET = 3'h0;
  localparam logic [7:0] WIDTH_RESET = 8'h01;
  localparam logic [11:0] COUNT_MAX = 12'hFFF;
  localparam logic [11:0] RESULT_NONE = 12'h000;

  typedef enum logic [1:0] {SSAT_SEL_AUX0, SSAT_SEL_AUX1, SSAT_SEL_AUX2, SSAT_SEL_CAL} ssat_sel_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ssat_bus_t;

endpackage

// ### logic/ssat_sync2.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
`timescale 1ns/1ps
module ssat_sync2 #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_r <= '0;
      syncOut <= '0;
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule

// ### logic/ssat_pulse_gen.sv
// Sync pulse stretcher: holds the ramp discharge for a programmed number of cycles.
`timescale 1ns/1ps
module ssat_pulse_gen
  import ssat_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic trigger,
  input wire logic [7:0] widthCycles,
  output logic pulseActive,
  output logic pulseEnd
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  wire loadNow = trigger;
  wire lastCycle = (cnt_r == 8'h01);
  // A width of zero still gives one cycle so the ramp always sees a discharge.
  wire [7:0] loadVal = (widthCycles == 8'h00) ? 8'h01 : widthCycles;
  assign cnt_nxt = loadNow ? loadVal : (cnt_r != 8'h00 ? cnt_r - 8'h01 : 8'h00);
  assign pulseActive = (cnt_r != 8'h00);
  assign pulseEnd = lastCycle && !loadNow;
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ### logic/ssat_timer_core.sv
// Top of the single-slope converter timer: registers, shared timer and four capture channels.
`timescale 1ns/1ps
module ssat_timer_core
  import ssat_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic pwmSyncReq,
  input wire logic [2:0] mainCmpAsync,
  input wire logic [3:0] auxCmpAsync,
  output logic [1:0] auxSelect,
  output logic rampDischarge,
  output logic [2:0] rampCurrentTrim
);

  // ****************************************
  // Register file
  // ****************************************
  ssat_bus_t bus;
  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  logic [15:0] mode_r;
  logic [7:0] width_r;
  logic [2:0] trim_r;
  logic [11:0] res_r [4];
  logic [3:0] tripped_r;
  logic [3:0] timeout_r;

  wire wrMode = bus.wr && (bus.addr == ADDR_MODE);
  wire wrWidth = bus.wr && (bus.addr == ADDR_WIDTH);
  wire wrTrim = bus.wr && (bus.addr == ADDR_TRIM);

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_r <= MODE_RESET;
      width_r <= WIDTH_RESET;
      trim_r <= TRIM_RESET;
    end else begin
      if (wrMode) begin
        mode_r <= bus.wdata;
      end
      if (wrWidth) begin
        width_r <= bus.wdata[7:0];
      end
      if (wrTrim) begin
        trim_r <= bus.wdata[2:0];
      end
    end
  end

  assign rampCurrentTrim = trim_r;
  assign auxSelect = mode_r[MODE_SEL_LSB+1:MODE_SEL_LSB];
  wire fastRate = mode_r[MODE_RATE_BIT];

  // Result registers have no write path, so software cannot disturb a capture.
  logic [15:0] rdMux;
  always_comb begin
    case (bus.addr)
      ADDR_MODE: rdMux = mode_r;
      ADDR_WIDTH: rdMux = {8'h00, width_r};
      ADDR_TRIM: rdMux = {13'h0000, trim_r};
      ADDR_RES1: rdMux = {4'h0, res_r[0]};
      ADDR_RES2: rdMux = {4'h0, res_r[1]};
      ADDR_RES3: rdMux = {4'h0, res_r[2]};
      ADDR_RESAUX: rdMux = {4'h0, res_r[3]};
      ADDR_STATUS: rdMux = {8'h00, timeout_r, tripped_r};
      default: rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      regRdata <= 16'h0000;
    end else begin
      regRdata <= bus.rd ? rdMux : 16'h0000;
    end
  end

  // ****************************************
  // Comparator synchronisers
  // ****************************************
  // All seven comparators pass the same two flops so their relative timing is kept.
  // The selector acts only on settled levels, so a select change cannot feed a runt
  // into a flop; the price is six extra flops for the unselected aux comparators.
  logic [6:0] cmpSyncAll;
  logic [3:0] cmpSync;
  ssat_sync2 #(.W(7)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .asyncIn({auxCmpAsync, mainCmpAsync}),
    .syncOut(cmpSyncAll)
  );
  wire [3:0] auxSync = cmpSyncAll[6:3];
  assign cmpSync = {auxSync[auxSelect], cmpSyncAll[2:0]};

  // ****************************************
  // Sync pulse and conversion window
  // ****************************************
  logic pulseActive;
  logic pulseEnd;
  ssat_pulse_gen u_pulse (
    .mclk(mclk),
    .reset(reset),
    .trigger(pwmSyncReq),
    .widthCycles(width_r),
    .pulseActive(pulseActive),
    .pulseEnd(pulseEnd)
  );
  assign rampDischarge = pulseActive;

  // The window simply runs from one sync pulse to the next, so double update mode,
  // which sends syncs every half period, halves the window without a mode bit here.
  typedef enum logic [1:0] {SSAT_IDLE, SSAT_DISCHARGE, SSAT_CONVERT} ssat_state_t;
  ssat_state_t state_r;
  ssat_state_t state_nxt;

  always_comb begin
    case (state_r)
      SSAT_IDLE: state_nxt = pwmSyncReq ? SSAT_DISCHARGE : SSAT_IDLE;
      SSAT_DISCHARGE: state_nxt = pulseEnd ? SSAT_CONVERT : SSAT_DISCHARGE;
      SSAT_CONVERT: state_nxt = pwmSyncReq ? SSAT_DISCHARGE : SSAT_CONVERT;
      default: state_nxt = SSAT_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= SSAT_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  wire converting = (state_r == SSAT_CONVERT);
  wire windowClose = converting && pwmSyncReq;

  // ****************************************
  // Shared timer
  // ****************************************
  // Slow rate ticks every other mclk, fast rate every mclk.
  logic half_r;
  logic [11:0] timer_r;
  logic [11:0] timer_nxt;
  wire tick = fastRate || half_r;
  wire atMax = (timer_r == COUNT_MAX);

  always_comb begin
    if (!converting) begin
      timer_nxt = 12'h000;
    end else if (tick && !atMax) begin
      timer_nxt = timer_r + 12'h001;
    end else begin
      timer_nxt = timer_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      half_r <= 1'b0;
      timer_r <= 12'h000;
    end else begin
      half_r <= converting ? ~half_r : 1'b0;
      timer_r <= timer_nxt;
    end
  end

  // ****************************************
  // Capture channels
  // ****************************************
  logic [3:0] cmpPrev_r;
  wire [3:0] tripEdge = cmpSync & ~cmpPrev_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmpPrev_r <= 4'h0;
      tripped_r <= 4'h0;
      timeout_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        res_r[i] <= RESULT_NONE;
      end
    end else begin
      cmpPrev_r <= cmpSync;
      for (int i = 0; i < 4; i++) begin
        if (windowClose) begin
          if (!tripped_r[i]) begin
            res_r[i] <= RESULT_NONE;
          end
          timeout_r[i] <= !tripped_r[i];
          tripped_r[i] <= 1'b0;
        end else if (converting && tripEdge[i] && !tripped_r[i]) begin
          res_r[i] <= timer_r;
          tripped_r[i] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_trim_reset: assert property (@(posedge mclk) $fell(reset) |-> rampCurrentTrim == TRIM_RESET)
    else $error("trim not zero after reset");
  a_timer_clear: assert property (@(posedge mclk) disable iff (reset)
    rampDischarge |-> ##1 timer_r == 12'h000) else $error("timer not cleared");
  a_timer_sat: assert property (@(posedge mclk) disable iff (reset)
    atMax && converting && !pwmSyncReq |=> atMax) else $error("timer passed 4095");
  a_slow_rate: assert property (@(posedge mclk) disable iff (reset)
    converting && !fastRate && !atMax && !pwmSyncReq ##1 converting && !fastRate && !pwmSyncReq
    |=> timer_r == $past(timer_r, 2) + 12'h001) else $error("slow rate wrong");
  a_fast_rate: assert property (@(posedge mclk) disable iff (reset)
    converting && fastRate && !atMax && !pwmSyncReq |=> timer_r == $past(timer_r) + 12'h001)
    else $error("fast rate wrong");
  a_capture_value: assert property (@(posedge mclk) disable iff (reset)
    converting && !pwmSyncReq && tripEdge[0] && !tripped_r[0] |=> res_r[0] == $past(timer_r))
    else $error("capture wrong");
  a_no_trip_zero: assert property (@(posedge mclk) disable iff (reset)
    windowClose && !tripped_r[3] |=> res_r[3] == RESULT_NONE) else $error("no zero");
  a_result_hold: assert property (@(posedge mclk) disable iff (reset)
    !converting |=> res_r[1] == $past(res_r[1])) else $error("result moved");
  a_discharge_width: assert property (@(posedge mclk) disable iff (reset)
    pwmSyncReq && width_r == 8'h03 && !wrWidth ##1 !pwmSyncReq [*4]
    |-> $past(rampDischarge, 1) && !rampDischarge) else $error("width wrong");
  a_sel_follow: assert property (@(posedge mclk) disable iff (reset)
    wrMode |=> auxSelect == $past(bus.wdata[1:0])) else $error("select wrong");

  // ****************************************
  // Register and capture checks
  // ****************************************
  a_width_store: assert property (@(posedge mclk) disable iff (reset)
    wrWidth |=> width_r == $past(bus.wdata[7:0]))
    else $error("width not stored");
  a_trim_store: assert property (@(posedge mclk) disable iff (reset)
    wrTrim |=> rampCurrentTrim == $past(bus.wdata[2:0]))
    else $error("trim not stored");
  a_trim_keep: assert property (@(posedge mclk) disable iff (reset)
    !wrTrim |=> $stable(rampCurrentTrim))
    else $error("trim moved");
  a_mode_store: assert property (@(posedge mclk) disable iff (reset)
    wrMode |=> mode_r == $past(bus.wdata))
    else $error("mode not stored");
  a_select_keep: assert property (@(posedge mclk) disable iff (reset)
    !wrMode |=> $stable(auxSelect))
    else $error("select moved");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (reset)
    !bus.rd |=> regRdata == 16'h0000)
    else $error("read data not idle");
  a_rdata_mode: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == ADDR_MODE |=> regRdata == $past(mode_r))
    else $error("mode read wrong");
  a_rdata_width: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == ADDR_WIDTH |=> regRdata == {8'h00, $past(width_r)})
    else $error("width read wrong");
  a_rdata_trim: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == ADDR_TRIM |=> regRdata == {13'h0000, $past(trim_r)})
    else $error("trim read wrong");
  a_rdata_res1: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == ADDR_RES1 |=> regRdata == {4'h0, $past(res_r[0])})
    else $error("result one read wrong");
  a_rdata_res2: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == ADDR_RES2 |=> regRdata == {4'h0, $past(res_r[1])})
    else $error("result two read wrong");
  a_rdata_res3: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == ADDR_RES3 |=> regRdata == {4'h0, $past(res_r[2])})
    else $error("result three read wrong");
  a_rdata_aux: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == ADDR_RESAUX |=> regRdata == {4'h0, $past(res_r[3])})
    else $error("aux result read wrong");
  a_rdata_status: assert property (@(posedge mclk) disable iff (reset)
    bus.rd && bus.addr == ADDR_STATUS |=> regRdata == {8'h00, $past(timeout_r), $past(tripped_r)})
    else $error("status read wrong");
  a_res_no_write: assert property (@(posedge mclk) disable iff (reset)
    converting && tripped_r[0] && !pwmSyncReq && bus.wr && bus.addr == ADDR_RES1
    |=> res_r[0] == $past(res_r[0])) else $error("result written");
  a_timer_idle: assert property (@(posedge mclk) disable iff (reset)
    !converting |=> timer_r == 12'h000)
    else $error("timer ran outside window");
  a_timer_start: assert property (@(posedge mclk) disable iff (reset)
    $rose(converting) |-> timer_r == 12'h000)
    else $error("timer not zero at start");
  a_discharge_state: assert property (@(posedge mclk) disable iff (reset)
    rampDischarge |-> state_r == SSAT_DISCHARGE)
    else $error("discharge outside its state");
  a_sync_starts: assert property (@(posedge mclk) disable iff (reset)
    pwmSyncReq |=> rampDischarge)
    else $error("sync gave no discharge");
  a_window_close: assert property (@(posedge mclk) disable iff (reset)
    windowClose |=> state_r == SSAT_DISCHARGE)
    else $error("window did not close");
  a_half_clear: assert property (@(posedge mclk) disable iff (reset)
    !converting |=> !half_r)
    else $error("rate phase not cleared");
  a_trip_once: assert property (@(posedge mclk) disable iff (reset)
    converting && tripped_r[0] && !pwmSyncReq |=> res_r[0] == $past(res_r[0]))
    else $error("second capture taken");
  a_capture_ch2: assert property (@(posedge mclk) disable iff (reset)
    converting && !pwmSyncReq && tripEdge[1] && !tripped_r[1] |=> res_r[1] == $past(timer_r))
    else $error("capture two wrong");
  a_capture_ch3: assert property (@(posedge mclk) disable iff (reset)
    converting && !pwmSyncReq && tripEdge[2] && !tripped_r[2] |=> res_r[2] == $past(timer_r))
    else $error("capture three wrong");
  a_capture_aux: assert property (@(posedge mclk) disable iff (reset)
    converting && !pwmSyncReq && tripEdge[3] && !tripped_r[3] |=> res_r[3] == $past(timer_r))
    else $error("aux capture wrong");
  a_timeout_flag: assert property (@(posedge mclk) disable iff (reset)
    windowClose |=> timeout_r == ~$past(tripped_r))
    else $error("timeout flags wrong");
  a_tripped_clear: assert property (@(posedge mclk) disable iff (reset)
    windowClose |=> tripped_r == 4'h0)
    else $error("trip flags kept");
  a_no_trip_ch1: assert property (@(posedge mclk) disable iff (reset)
    windowClose && !tripped_r[0] |=> res_r[0] == RESULT_NONE)
    else $error("no zero on one");
  a_no_trip_ch2: assert property (@(posedge mclk) disable iff (reset)
    windowClose && !tripped_r[1] |=> res_r[1] == RESULT_NONE)
    else $error("no zero on two");
  a_no_trip_ch3: assert property (@(posedge mclk) disable iff (reset)
    windowClose && !tripped_r[2] |=> res_r[2] == RESULT_NONE)
    else $error("no zero on three");
  a_tripped_idle: assert property (@(posedge mclk) disable iff (reset)
    !converting |=> tripped_r == $past(tripped_r))
    else $error("trip outside window");
  a_hold_ch1: assert property (@(posedge mclk) disable iff (reset)
    !converting |=> res_r[0] == $past(res_r[0]))
    else $error("result one moved");
  a_hold_ch3: assert property (@(posedge mclk) disable iff (reset)
    !converting |=> res_r[2] == $past(res_r[2]))
    else $error("result three moved");
  a_hold_aux: assert property (@(posedge mclk) disable iff (reset)
    !converting |=> res_r[3] == $past(res_r[3]))
    else $error("aux result moved");

  c_capture: cover property (@(posedge mclk) converting && tripEdge[0]);
  c_timeout: cover property (@(posedge mclk) windowClose && !tripped_r[3]);
  c_saturate: cover property (@(posedge mclk) converting && atMax);
  c_cal_sel: cover property (@(posedge mclk) auxSelect == 2'h3 && tripEdge[3]);
  c_slow_tick: cover property (@(posedge mclk) converting && !fastRate && tick);

endmodule

// ### verif/ssat_ramp_model.sv
// Behavioural ramp capacitor, current source and the seven comparators of the converter.
`timescale 1ns/1ps
module ssat_ramp_model (
  input wire logic mclk,
  input wire logic rampDischarge,
  input wire logic [6:0][15:0] thr,
  output logic [2:0] mainCmpAsync,
  output logic [3:0] auxCmpAsync
);
  // ****************************************
  // Ramp and comparators
  // ****************************************
  int ramp = 0;
  logic [6:0] cmp = 7'h00;

  assign {auxCmpAsync, mainCmpAsync} = cmp;

  // The comparators are not clocked, so they move a few ns after the edge.
  always @(posedge mclk) begin
    #3;
    ramp = rampDischarge ? 0 : ramp + 1;
    for (int i = 0; i < 7; i++) begin
      cmp[i] = !rampDischarge && ramp >= int'(thr[i]);
    end
  end
endmodule

// ### verif/single_slope_adc_timer_test.sv
// Self-checking bench for the single-slope converter timer and capture block.
`timescale 1ns/1ps
module single_slope_adc_timer_test
  import ssat_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic pwmSyncReq = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic [15:0] regRdata;
  logic [15:0] rv;
  logic [2:0] mainCmpAsync;
  logic [2:0] rampCurrentTrim;
  logic [3:0] auxCmpAsync;
  logic [1:0] auxSelect;
  logic rampDischarge;
  logic [6:0][15:0] thr = '0;
  int mismatches = 0;
  int comparisons = 0;
  int seed = 32'h1674;
  int r[4];

  always #10 mclk = ~mclk;

  ssat_timer_core ssat_timer_core_i (.mclk, .reset, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .pwmSyncReq, .mainCmpAsync, .auxCmpAsync, .auxSelect, .rampDischarge,
    .rampCurrentTrim);
  ssat_ramp_model ssat_ramp_model_i (.mclk, .rampDischarge, .thr, .mainCmpAsync, .auxCmpAsync);

  // ****************************************
  // Bus cycles and checks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask

  task automatic conv(input int w, input int n);
    int k;
    @(posedge mclk);
    pwmSyncReq <= 1'b1;
    @(posedge mclk);
    pwmSyncReq <= 1'b0;
    k = 0;
    #1;
    while (rampDischarge === 1'b1 && k < 300) begin
      k++;
      @(posedge mclk);
      #1;
    end
    chk(16'(k), 16'(w));
    repeat (n) @(posedge mclk);
  endtask

  task automatic read_all();
    for (int c = 0; c < 4; c++) begin
      rd(ADDR_RES1 + 4'(c));
      r[c] = int'(rv);
    end
  endtask

  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(ADDR_TRIM);
    chk(rv, 16'h0000);
    rd(ADDR_MODE);
    chk(rv, MODE_RESET);
    rd(4'h9);
    chk(rv, 16'h0000);
    wr(ADDR_TRIM, 16'h0007);
    rd(ADDR_TRIM);
    chk(rv, 16'h0007);
    chk(16'(rampCurrentTrim), 16'h0007);
    wr(ADDR_WIDTH, 16'h0005);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_MODE, 16'h0080 | 16'(s));
      for (int i = 0; i < 7; i++) begin
        thr[i] = 16'(20 + ($random(seed) & 511));
      end
      conv(5, 600);
      read_all();
      chk(16'(auxSelect), 16'(s));
      chk(16'(r[1] - r[0]), thr[1] - thr[0]);
      chk(16'(r[2] - r[0]), thr[2] - thr[0]);
      chk(16'(r[3] - r[0]), thr[3 + s] - thr[0]);
      chk(16'(r[0] + 2 >= thr[0] && r[0] <= thr[0] + 6), 16'h0001);
    end
    // Slow rate: an even gap in cycles halves exactly whatever the count phase is.
    wr(ADDR_MODE, 16'h0000);
    thr[0] = 16'd100;
    thr[1] = 16'd300;
    thr[2] = 16'd700;
    conv(5, 1300);
    read_all();
    chk(16'(r[1] - r[0]), 16'd100);
    chk(16'(r[2] - r[0]), 16'd300);
    wr(ADDR_MODE, 16'h0080);
    wr(ADDR_WIDTH, 16'h0003);
    thr[0] = 16'd4180;
    thr[1] = 16'hFFFF;
    conv(3, 4300);
    rd(ADDR_RES1);
    chk(rv, {4'h0, COUNT_MAX});
    wr(ADDR_RES1, 16'h0123);
    rd(ADDR_RES1);
    chk(rv, {4'h0, COUNT_MAX});
    conv(3, 10);
    rd(ADDR_RES2);
    chk(rv, {4'h0, RESULT_NONE});
    rd(ADDR_STATUS);
    chk(rv, 16'h0020);
    end_sim();
  end

  initial begin
    #400000;
    mismatches++;
    end_sim();
  end
endmodule
